// ==== scpbr_pkg.sv ====
package scpbr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // serial instruction and data framing
    localparam int unsigned       INST_W     = 16;
    localparam int unsigned       ADDR_W     = 13;
    localparam int unsigned       BYTE_W     = 8;
    localparam logic [3:0]        INST_LAST  = 4'hF;
    localparam logic [3:0]        BYTE_LAST  = 4'h7;
    localparam logic [2:0]        BIT_LAST   = 3'h7;
    localparam logic [1:0]        LEN_STREAM = 2'h3;
    localparam logic [1:0]        LEN_ONE    = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // serial register map
    localparam logic [ADDR_W-1:0] CFG_ADDR      = 13'h0000;
    localparam int unsigned       LSB_FIRST_BIT = 6;
    localparam logic [ADDR_W-1:0] RDSEL_ADDR    = 13'h0004;
    localparam int unsigned       RDSEL_BIT     = 0;
    localparam logic [ADDR_W-1:0] UPD_ADDR      = 13'h0005;
    localparam int unsigned       UPD_BIT       = 0;

    ////////////////////////////////////////////////////////////////////////////
    // bus register map
    localparam int unsigned       WB_AW         = 8;
    localparam logic [WB_AW-1:0]  WB_IMAGE_BASE = 8'h00;
    localparam logic [WB_AW-1:0]  WB_CTRL       = 8'h40;
    localparam logic [WB_AW-1:0]  WB_STATUS     = 8'h44;
    localparam int unsigned       CTRL_EN_BIT   = 0;
    localparam logic              CTRL_EN_RST   = 1'b1;
    localparam logic [31:0]       WB_ZERO       = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        PH_INST = 2'b00,
        PH_DATA = 2'b01,
        PH_DONE = 2'b10
    } scpbr_phase_e;

    typedef struct packed {
        logic              read_not_write_bit;
        logic [1:0]        transfer_length_code;
        logic [ADDR_W-1:0] start_address_field;
    } scpbr_inst_s;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [WB_AW-1:0]  adr;
        logic [31:0]       dat;
    } scpbr_wb_req_s;

endpackage

// ==== scpbr_top.sv ====
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module scpbr_top #(
    parameter int unsigned           NREG        = 8,
    parameter logic [NREG-1:0]       RO_MASK     = 8'h80,
    // top byte is a read-only code, value arbitrary
    parameter logic [NREG*8-1:0]     REG_DEFAULT = 64'h5A00_0000_0000_0000
) (
    // system clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    // bus slave
    input  wire scpbr_pkg::scpbr_wb_req_s i_wb,
    output logic                          o_wb_ack,
    output logic [31:0]                   o_wb_dat,
    // serial link
    input  wire logic                     i_sclk,
    input  wire logic                     i_cs_n,
    input  wire logic                     i_sdio_i,
    output logic                          o_sdio_o,
    output logic                          o_sdio_oe
);
    import scpbr_pkg::*;

    localparam int unsigned IW     = (NREG > 1) ? $clog2(NREG) : 1;
    localparam logic [IW-1:0] CFG_IDX   = IW'(CFG_ADDR);
    localparam logic [IW-1:0] RDSEL_IDX = IW'(RDSEL_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // link domain state
    logic                          lrst_meta_r;
    logic                          lrst_r;
    logic                          en_meta_r;
    logic                          en_r;
    scpbr_phase_e                  phase_r;
    scpbr_phase_e                  phase_nxt;
    logic [3:0]                    bcnt_r;
    logic [3:0]                    bcnt_nxt;
    logic [INST_W-1:0]             inst_r;
    logic [INST_W-1:0]             inst_nxt;
    logic [BYTE_W-1:0]             dbyte_r;
    logic [BYTE_W-1:0]             dbyte_nxt;
    logic [BYTE_W-1:0]             rd_byte_r;
    logic [BYTE_W-1:0]             rd_byte_nxt;
    logic [ADDR_W-1:0]             addr_r;
    logic [ADDR_W-1:0]             addr_nxt;
    logic                          rnw_r;
    logic                          rnw_nxt;
    logic [1:0]                    len_r;
    logic [1:0]                    len_nxt;
    logic [1:0]                    left_r;
    logic [1:0]                    left_nxt;
    logic                          upd_tgl_r;
    logic                          upd_tgl_nxt;
    logic [NREG-1:0][BYTE_W-1:0]   shadow_r;
    logic [NREG-1:0][BYTE_W-1:0]   shadow_nxt;
    logic [NREG-1:0][BYTE_W-1:0]   active_r;
    logic [NREG-1:0][BYTE_W-1:0]   active_nxt;
    logic                          sdo_r;
    logic                          sdo_nxt;
    logic                          oe_r;
    logic                          oe_nxt;
    logic                          ctrl_en_r;

    logic                          lsb_first;
    logic [INST_W-1:0]             inst_sh;
    logic [BYTE_W-1:0]             byte_sh;
    scpbr_inst_s                   inst;
    logic                          live;
    logic                          byte_done;
    logic                          wr_fire;
    logic                          upd_fire;
    logic [ADDR_W-1:0]             addr_step;

    function automatic logic [BYTE_W-1:0] rd_val(input logic [ADDR_W-1:0] a,
                                                 input logic [NREG-1:0][BYTE_W-1:0] sh,
                                                 input logic [NREG-1:0][BYTE_W-1:0] ac);
        logic [BYTE_W-1:0] v;
        v = '0;
        if (a < ADDR_W'(NREG)) begin
            v = ac[RDSEL_IDX][RDSEL_BIT] ? sh[a[IW-1:0]] : ac[a[IW-1:0]];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link shifter and sequencer
    always_comb begin
        lsb_first = active_r[CFG_IDX][LSB_FIRST_BIT];
        inst_sh   = lsb_first ? {i_sdio_i, inst_r[INST_W-1:1]} : {inst_r[INST_W-2:0], i_sdio_i};
        byte_sh   = lsb_first ? {i_sdio_i, dbyte_r[BYTE_W-1:1]} : {dbyte_r[BYTE_W-2:0], i_sdio_i};
        inst      = scpbr_inst_s'(inst_sh);
        live      = !i_cs_n && en_r;
        byte_done = live && phase_r == PH_DATA && bcnt_r == BYTE_LAST;
        wr_fire   = byte_done && !rnw_r;
        upd_fire  = wr_fire && addr_r == UPD_ADDR && byte_sh[UPD_BIT];
        addr_step = lsb_first ? addr_r + ADDR_W'(1) : addr_r - ADDR_W'(1);

        phase_nxt   = phase_r;
        bcnt_nxt    = bcnt_r;
        inst_nxt    = inst_r;
        dbyte_nxt   = dbyte_r;
        rd_byte_nxt = rd_byte_r;
        addr_nxt    = addr_r;
        rnw_nxt     = rnw_r;
        len_nxt     = len_r;
        left_nxt    = left_r;
        upd_tgl_nxt = upd_tgl_r ^ upd_fire;
        if (lrst_r || !live) begin
            phase_nxt = PH_INST;
            bcnt_nxt  = '0;
            if (lrst_r) begin
                upd_tgl_nxt = 1'b0;
                rnw_nxt     = 1'b0;
                len_nxt     = LEN_ONE;
                left_nxt    = '0;
                addr_nxt    = '0;
                rd_byte_nxt = '0;
            end
        end else begin
            case (phase_r)
                PH_INST: begin
                    inst_nxt = inst_sh;
                    bcnt_nxt = bcnt_r + 4'h1;
                    if (bcnt_r == INST_LAST) begin
                        phase_nxt   = PH_DATA;
                        bcnt_nxt    = '0;
                        rnw_nxt     = inst.read_not_write_bit;
                        len_nxt     = inst.transfer_length_code;
                        left_nxt    = inst.transfer_length_code;
                        addr_nxt    = inst.start_address_field;
                        rd_byte_nxt = rd_val(inst.start_address_field, shadow_r, active_r);
                    end
                end
                PH_DATA: begin
                    dbyte_nxt = byte_sh;
                    bcnt_nxt  = bcnt_r + 4'h1;
                    if (byte_done) begin
                        bcnt_nxt    = '0;
                        addr_nxt    = addr_step;
                        rd_byte_nxt = rd_val(addr_step, shadow_r, active_r);
                        if (len_r != LEN_STREAM) begin
                            if (left_r == 2'h0) begin
                                phase_nxt = PH_DONE;
                            end else begin
                                left_nxt = left_r - 2'h1;
                            end
                        end
                    end
                end
                PH_DONE: begin
                    phase_nxt = PH_DONE;
                end
                default: begin
                    phase_nxt = PH_INST;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file, one entry per register
    for (genvar g = 0; g < NREG; g++) begin : g_reg
        always_comb begin
            shadow_nxt[g] = shadow_r[g];
            active_nxt[g] = active_r[g];
            if (lrst_r) begin
                shadow_nxt[g] = REG_DEFAULT[g*8 +: 8];
                active_nxt[g] = REG_DEFAULT[g*8 +: 8];
            end else if (!RO_MASK[g]) begin
                if (wr_fire && addr_r == ADDR_W'(g)) begin
                    shadow_nxt[g] = byte_sh;
                end
                if (ADDR_W'(g) == UPD_ADDR) begin
                    shadow_nxt[g][UPD_BIT] = 1'b0;
                end
                if (upd_fire) begin
                    active_nxt[g] = shadow_nxt[g];
                end
            end else begin
                shadow_nxt[g] = REG_DEFAULT[g*8 +: 8];
            end
        end
    end

    always_ff @(posedge i_sclk) begin
        lrst_meta_r <= i_rst;
        lrst_r      <= lrst_meta_r;
        en_meta_r   <= ctrl_en_r;
        en_r        <= en_meta_r;
        phase_r     <= phase_nxt;
        bcnt_r      <= bcnt_nxt;
        inst_r      <= inst_nxt;
        dbyte_r     <= dbyte_nxt;
        rd_byte_r   <= rd_byte_nxt;
        addr_r      <= addr_nxt;
        rnw_r       <= rnw_nxt;
        len_r       <= len_nxt;
        left_r      <= left_nxt;
        upd_tgl_r   <= upd_tgl_nxt;
        shadow_r    <= shadow_nxt;
        active_r    <= active_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data launch on falling edge
    always_comb begin
        sdo_nxt = lsb_first ? rd_byte_r[bcnt_r[2:0]] : rd_byte_r[BIT_LAST - bcnt_r[2:0]];
        // single pin, driven only in read data
        oe_nxt  = live && !lrst_r && phase_r == PH_DATA && rnw_r;
        if (lrst_r) begin
            sdo_nxt = 1'b0;
        end
    end

    always_ff @(negedge i_sclk) begin
        sdo_r <= sdo_nxt;
        oe_r  <= oe_nxt;
    end

    assign o_sdio_o  = sdo_r;
    // release as soon as select rises
    assign o_sdio_oe = oe_r && !i_cs_n;

    ////////////////////////////////////////////////////////////////////////////
    // system domain: bus slave and active image
    logic                          ctrl_en_nxt;
    logic                          tgl_meta_r;
    logic                          tgl_s_r;
    logic                          tgl_d_r;
    logic [NREG-1:0][BYTE_W-1:0]   image_r;
    logic [NREG-1:0][BYTE_W-1:0]   image_nxt;
    logic [15:0]                   upd_cnt_r;
    logic [15:0]                   upd_cnt_nxt;
    logic                          ack_r;
    logic                          ack_nxt;
    logic [31:0]                   dat_r;
    logic [31:0]                   dat_nxt;
    logic                          upd_seen;
    logic [WB_AW-3:0]              wb_idx;

    always_comb begin
        upd_seen    = tgl_s_r ^ tgl_d_r;
        wb_idx      = i_wb.adr[WB_AW-1:2];
        ack_nxt     = i_wb.cyc && i_wb.stb && !ack_r;
        ctrl_en_nxt = ctrl_en_r;
        image_nxt   = upd_seen ? active_r : image_r;
        upd_cnt_nxt = upd_cnt_r + {15'h0000, upd_seen};
        dat_nxt     = WB_ZERO;
        if (i_wb.adr == WB_CTRL) begin
            dat_nxt[CTRL_EN_BIT] = ctrl_en_r;
            if (ack_nxt && i_wb.we && i_wb.sel[0]) begin
                ctrl_en_nxt = i_wb.dat[CTRL_EN_BIT];
            end
        end else if (i_wb.adr == WB_STATUS) begin
            dat_nxt[15:0] = upd_cnt_r;
        end else if (i_wb.adr >= WB_IMAGE_BASE && i_wb.adr[1:0] == 2'h0 && wb_idx < (WB_AW-2)'(NREG)) begin
            dat_nxt[BYTE_W-1:0] = image_r[wb_idx[IW-1:0]];
        end
        if (!ack_nxt) begin
            dat_nxt = WB_ZERO;
        end
        if (i_rst) begin
            ctrl_en_nxt = CTRL_EN_RST;
            image_nxt   = REG_DEFAULT;
            upd_cnt_nxt = '0;
            ack_nxt     = 1'b0;
            dat_nxt     = WB_ZERO;
        end
    end

    always_ff @(posedge i_clk) begin
        tgl_meta_r <= upd_tgl_r;
        tgl_s_r    <= tgl_meta_r;
        tgl_d_r    <= tgl_s_r;
        ctrl_en_r  <= ctrl_en_nxt;
        image_r    <= image_nxt;
        upd_cnt_r  <= upd_cnt_nxt;
        ack_r      <= ack_nxt;
        dat_r      <= dat_nxt;
    end

    assign o_wb_ack = ack_r;
    assign o_wb_dat = dat_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_ro_keep;
        @(posedge i_sclk) disable iff (lrst_r)
        wr_fire && addr_r < ADDR_W'(NREG) && RO_MASK[addr_r[IW-1:0]]
            |=> active_r == $past(active_r) && shadow_r == $past(shadow_r);
    endproperty
    a_ro_keep: assert property (p_ro_keep) else $error("read-only register changed by write");

    property p_shadow_only;
        @(posedge i_sclk) disable iff (lrst_r)
        wr_fire && !upd_fire |=> active_r == $past(active_r);
    endproperty
    a_shadow_only: assert property (p_shadow_only) else $error("active changed without update");

    property p_update;
        @(posedge i_sclk) disable iff (lrst_r)
        upd_fire |=> upd_tgl_r != $past(upd_tgl_r) && active_r[RDSEL_IDX] == shadow_r[RDSEL_IDX];
    endproperty
    a_update: assert property (p_update) else $error("update did not copy shadow");

    property p_all_at_once;
        @(posedge i_sclk) disable iff (lrst_r)
        upd_fire |=> active_r == ($past(active_nxt));
    endproperty
    a_all_at_once: assert property (p_all_at_once) else $error("update not applied as one");

    property p_self_clear;
        @(posedge i_sclk) disable iff (lrst_r)
        upd_fire |=> !shadow_r[IW'(UPD_ADDR)][UPD_BIT] && !active_r[IW'(UPD_ADDR)][UPD_BIT];
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("update bit did not clear");

    property p_hiz;
        @(posedge i_sclk) disable iff (lrst_r)
        i_cs_n |-> !o_sdio_oe ##1 (phase_r == PH_INST && bcnt_r == 4'h0);
    endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven or frame kept with select high");

    property p_abort;
        @(posedge i_sclk) disable iff (lrst_r)
        phase_r == PH_DATA && bcnt_r != 4'h0 && i_cs_n |=> bcnt_r == 4'h0 && phase_r == PH_INST;
    endproperty
    a_abort: assert property (p_abort) else $error("partial byte not dropped");

    property p_step;
        @(posedge i_sclk) disable iff (lrst_r)
        byte_done |=> addr_r == ($past(lsb_first) ? $past(addr_r) + 13'h0001 : $past(addr_r) - 13'h0001);
    endproperty
    a_step: assert property (p_step) else $error("address stepped wrong way");

    property p_inst_len;
        @(posedge i_sclk) disable iff (lrst_r)
        live && phase_r == PH_INST && bcnt_r == INST_LAST |=> phase_r == PH_DATA && bcnt_r == 4'h0;
    endproperty
    a_inst_len: assert property (p_inst_len) else $error("instruction not 16 bits");

    property p_defaults;
        @(posedge i_clk) disable iff (1'b0)
        i_rst |=> image_r == REG_DEFAULT && ctrl_en_r && !o_wb_ack;
    endproperty
    a_defaults: assert property (p_defaults) else $error("reset defaults missing");

    property p_ack_pulse;
        @(posedge i_clk) disable iff (i_rst)
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

endmodule

// ==== scpbr_host.sv ====
`timescale 1ns/10ps
module scpbr_host (
    // serial pins toward the port
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdio,
    output logic      o_oe,
    // resolved data pin
    input  wire logic i_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // idle pins, clock stands low except while a task pulses it
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdio = 1'b0;
        o_oe   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock pulses with select high
    task automatic idle(input int n);
        o_cs_n = 1'b1;
        o_oe   = 1'b0;
        repeat (n) begin
            #7.5 o_sclk = 1'b1;
            #7.5 o_sclk = 1'b0;
        end
    endtask

    // instruction then data bits, select low throughout
    task automatic xfer(input logic lsb, input logic [15:0] inst, input int nbits,
                        input logic [31:0] wd, output logic [31:0] rd);
        int i;
        int p;
        rd     = 32'h0000_0000;
        o_cs_n = 1'b0;
        o_oe   = 1'b1;
        for (i = 0; i < 16 + nbits; i++) begin
            p = (i < 16) ? (lsb ? i : 15 - i) : (i - 16) / 8 * 8 + (lsb ? i % 8 : 7 - i % 8);
            if (i == 16 && inst[15]) begin
                o_oe = 1'b0;
            end
            o_sdio = (i < 16) ? inst[p] : wd[p];
            #7.5 o_sclk = 1'b1;
            if (i >= 16 && inst[15]) begin
                rd[p] = i_pin;
            end
            #7.5 o_sclk = 1'b0;
        end
        idle(1);
    endtask

endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import scpbr_pkg::*;

    // top byte is the read-only code, value arbitrary
    localparam logic [63:0] DEFS = 64'hC300_0000_0000_0000;
    typedef struct {
        logic [12:0] a;
        logic [7:0]  d;
    } scpbr_row_s;

    logic          i_clk = 1'b0;
    logic          i_rst = 1'b1;
    scpbr_wb_req_s wb    = '0;
    logic          ack;
    logic [31:0]   wdat;
    logic          sdo;
    logic          soe;
    logic          sclk;
    logic          cs_n;
    logic          h_o;
    logic          h_oe;
    logic          junk  = 1'b0;
    logic [7:0]    sh [8];
    logic [7:0]    act [8];
    logic [31:0]   q;
    logic [31:0]   rd;
    logic          lsb   = 1'b0;
    int            failures = 0;
    int            compares = 0;
    int            cycles   = 0;
    int            n_upd    = 0;
    wire           pin   = (soe === 1'b1) ? sdo : (h_oe ? h_o : junk);

    always #50 i_clk = ~i_clk;
    always @(negedge sclk) junk <= ~junk;

    scpbr_top #(.NREG(8), .RO_MASK(8'h80), .REG_DEFAULT(DEFS)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_wb(wb), .o_wb_ack(ack), .o_wb_dat(wdat),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio_i(pin), .o_sdio_o(sdo), .o_sdio_oe(soe));
    scpbr_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(h_o), .o_oe(h_oe), .i_pin(pin));

    ////////////////////////////////////////////////////////////////////////////
    // checks, verdict, bus and register helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic results();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n == 20) begin
            failures++;
            results();
        end
        q = wdat;
        wb <= '0;
    endtask

    task automatic sw(input logic [12:0] a, input logic [7:0] d);
        host_u.xfer(lsb, {3'b000, a}, 8, {24'h0, d}, rd);
        if (a != 13'h7) sh[a[2:0]] = d;
    endtask

    task automatic upd();
        host_u.xfer(lsb, 16'h0005, 8, 32'h0000_0001, rd);
        foreach (act[i]) act[i] = sh[i];
        n_upd++;
        repeat (10) @(posedge i_clk);
    endtask

    task automatic img_all();
        for (int i = 0; i < 8; i++) begin
            wbx(1'b0, 8'(4 * i), 32'h0);
            chk("image", {24'h0, act[i]}, q);
        end
    endtask

    // pin released whenever select is high
    always @(posedge sclk) if (cs_n === 1'b1) chk("pin enable", 32'h0, {31'h0, soe});

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        scpbr_row_s rows [5] = '{'{13'h1, 8'hA5}, '{13'h2, 8'h3C}, '{13'h3, 8'hFF},
                                 '{13'h6, 8'h81}, '{13'h7, 8'h12}};
        foreach (sh[i]) sh[i] = DEFS[8*i +: 8];
        foreach (act[i]) act[i] = DEFS[8*i +: 8];
        host_u.idle(4);
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        host_u.idle(3);
        img_all();
        wbx(1'b0, WB_CTRL, 32'h0);
        chk("enable", 32'h1, q);
        wbx(1'b0, 8'h80, 32'h0);
        chk("unmapped", 32'h0, q);
        foreach (rows[i]) begin
            sw(rows[i].a, rows[i].d);
            wbx(1'b0, 8'(4 * rows[i].a), 32'h0);
            chk("held", {24'h0, act[rows[i].a[2:0]]}, q);
        end
        upd();
        img_all();
        host_u.xfer(1'b0, 16'h8005, 8, 32'h0, rd);
        chk("update bit", 32'h0, rd);
        host_u.xfer(1'b0, 16'hA003, 16, 32'h0, rd);
        chk("read pair", {16'h0, act[2], act[3]}, rd);
        host_u.xfer(1'b0, 16'h4003, 24, 32'h0033_2211, rd);
        sh[3] = 8'h11;
        sh[2] = 8'h22;
        sh[1] = 8'h33;
        upd();
        img_all();
        host_u.xfer(1'b0, 16'h0006, 4, 32'h0000_00F0, rd);
        upd();
        img_all();
        wbx(1'b1, WB_CTRL, 32'h0);
        host_u.idle(3);
        host_u.xfer(1'b0, 16'h0006, 8, 32'h0000_0077, rd);
        wbx(1'b1, WB_CTRL, 32'h1);
        host_u.idle(3);
        upd();
        img_all();
        wbx(1'b1, 8'h04, 32'h0000_00EE);
        wbx(1'b0, 8'h04, 32'h0);
        chk("image write", {24'h0, act[1]}, q);
        wbx(1'b0, WB_STATUS, 32'h0);
        chk("updates", 32'(n_upd), q);
        sw(13'h0, 8'h40);
        upd();
        lsb = 1'b1;
        host_u.xfer(1'b1, 16'h6001, 32, 32'h04C3_5A96, rd);
        sh[1] = 8'h96;
        sh[2] = 8'h5A;
        sh[3] = 8'hC3;
        sh[4] = 8'h04;
        upd();
        img_all();
        host_u.xfer(1'b1, 16'hA001, 16, 32'h0, rd);
        chk("lsb read", {16'h0, act[2], act[1]}, rd);
        results();
    end

endmodule
